// [logic/act_pkg.sv]
// constants and carriers for the amplifier control tail register bank
// assumes a byte-wide register port fed by an external two-wire protocol engine
// Behaviour
// [R1] overheat_retry_disable at 0 lets the device retry after an overheat fault, at 1 it does not.
// [R2] an 8-bit running checksum folds over every bus transaction and reads back at its register; a byte arriving with a checksum write is dropped.
// [R3] any write to the checksum register clears the checksum instead of storing the byte.
// [R4] the book select register picks book 0 to 255 and resets to book 0.
// [R5] the host powers the supplies, releases the active-low reset pin, then programs over the bus; act_regs takes an active-high rst_i instead.
// [R6] the device keeps measuring load current and voltage and streams them out as digital words.
// [R7] after any reset the host waits 100 us for one-time-programmable data to load before commands.
// [R8] the checksum takes every transferred byte in order, polynomial x^8+x^2+x+1 (0x07); a byte in the same cycle as a checksum write is dropped.
package act_pkg;
  localparam logic [7:0] ADDR_PROT_CFG = 8'h58;
  localparam logic [7:0] ADDR_CHECKSUM = 8'h7e;
  localparam logic [7:0] ADDR_BOOK = 8'h7f;
  localparam logic [7:0] PROT_CFG_RESET = 8'h03;
  localparam int RETRY_BIT = 2;
  localparam logic [7:0] CHECKSUM_RESET = 8'h00;
  localparam logic [7:0] BOOK_RESET = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam int OTP_LOAD_NS = 100000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int OTP_LOAD_CYCLES = (OTP_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SENSE_SAMPLE_CYCLES = 2604;
  localparam logic [7:0] RETRY_DELAY_RESET = 8'hff;

  typedef struct packed {
    logic [15:0] current;
    logic [15:0] voltage;
  } act_sense_t;

  typedef enum logic [1:0] {
    ACT_RUN = 2'b00,
    ACT_FAULT = 2'b01,
    ACT_WAIT = 2'b10,
    ACT_LATCHED = 2'b11
  } act_prot_state_t;
endpackage : act_pkg

// [logic/act_regs.sv]
// amplifier control tail registers: protection config, bus checksum, book select
// assumes the protocol engine gives one-cycle pulses for register access and bytes
`timescale 1ns/1ps
module act_regs #(
  parameter int RETRY_CYCLES = 1000,
  parameter int SENSE_CYCLES = act_pkg::SENSE_SAMPLE_CYCLES,
  parameter int OTP_CYCLES = act_pkg::OTP_LOAD_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // transferred byte stream for checksum
  input wire logic bus_byte_valid_i,
  input wire logic [7:0] bus_byte_i,
  // protection
  input wire logic overheat_i,
  output logic amp_enable_o,
  output logic overheat_latched_o,
  output logic otp_ready_o,
  // sense stream
  input wire act_pkg::act_sense_t sense_i,
  output act_pkg::act_sense_t sense_o,
  output logic sense_valid_o
);
  // counter widths below bound each wait; refuse what they cannot count
  if (RETRY_CYCLES < 1 || RETRY_CYCLES > 65536) begin : g_bad_retry
    $error("act_regs: RETRY_CYCLES out of range");
  end
  if (SENSE_CYCLES < 1 || SENSE_CYCLES > 65536) begin : g_bad_sense
    $error("act_regs: SENSE_CYCLES out of range");
  end
  if (OTP_CYCLES < 1 || OTP_CYCLES > 131072) begin : g_bad_otp
    $error("act_regs: OTP_CYCLES out of range");
  end

  function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ act_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8_byte

  logic [7:0] prot_cfg_q, prot_cfg_d;
  logic [7:0] checksum_q, checksum_d;
  logic [7:0] book_q, book_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic overheat_retry_disable;

  // policy bit read straight from the stored byte, no shadow copy to drift
  assign overheat_retry_disable = prot_cfg_q[act_pkg::RETRY_BIT]; // [R1]

  // register file
  always_comb begin
    prot_cfg_d = prot_cfg_q;
    checksum_d = checksum_q;
    book_d = book_q;
    if (bus_byte_valid_i) begin
      checksum_d = crc8_byte(checksum_q, bus_byte_i); // [R2] [R8]
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        act_pkg::ADDR_PROT_CFG: prot_cfg_d = reg_wdata_i;
        act_pkg::ADDR_CHECKSUM: checksum_d = act_pkg::CHECKSUM_RESET; // [R3]
        act_pkg::ADDR_BOOK: book_d = reg_wdata_i; // [R4]
        default: ;
      endcase
    end
    rvalid_d = reg_rd_i;
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      case (reg_addr_i)
        act_pkg::ADDR_PROT_CFG: rdata_d = prot_cfg_q;
        act_pkg::ADDR_CHECKSUM: rdata_d = checksum_q; // [R2]
        act_pkg::ADDR_BOOK: rdata_d = book_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prot_cfg_q <= act_pkg::PROT_CFG_RESET;
      checksum_q <= act_pkg::CHECKSUM_RESET;
      book_q <= act_pkg::BOOK_RESET; // [R4]
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      prot_cfg_q <= prot_cfg_d;
      checksum_q <= checksum_d;
      book_q <= book_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;

  // otp load window after reset; host is expected to wait it out
  logic [16:0] otp_cnt_q, otp_cnt_d;
  logic otp_ready_q, otp_ready_d;

  always_comb begin
    otp_cnt_d = otp_cnt_q;
    otp_ready_d = otp_ready_q;
    if (!otp_ready_q) begin
      if (otp_cnt_q == 17'(OTP_CYCLES - 1)) begin
        otp_ready_d = 1'b1; // [R7]
      end else begin
        otp_cnt_d = otp_cnt_q + 17'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      otp_cnt_q <= '0;
      otp_ready_q <= 1'b0;
    end else begin
      otp_cnt_q <= otp_cnt_d;
      otp_ready_q <= otp_ready_d;
    end
  end

  assign otp_ready_o = otp_ready_q;

  // overheat handling; retry waits for the fault to clear then a hold-off
  act_pkg::act_prot_state_t st_q, st_d;
  logic [15:0] retry_cnt_q, retry_cnt_d;
  logic amp_en_q, amp_en_d;
  logic latched_q, latched_d;

  always_comb begin
    st_d = st_q;
    retry_cnt_d = retry_cnt_q;
    case (st_q)
      act_pkg::ACT_RUN: begin
        if (overheat_i) st_d = act_pkg::ACT_FAULT;
      end
      act_pkg::ACT_FAULT: begin
        if (overheat_retry_disable) begin
          st_d = act_pkg::ACT_LATCHED; // [R1]
        end else if (!overheat_i) begin
          st_d = act_pkg::ACT_WAIT; // [R1]
          retry_cnt_d = '0;
        end
      end
      act_pkg::ACT_WAIT: begin
        if (overheat_i) begin
          st_d = act_pkg::ACT_FAULT;
        end else if (retry_cnt_q == 16'(RETRY_CYCLES - 1)) begin
          st_d = act_pkg::ACT_RUN;
        end else begin
          retry_cnt_d = retry_cnt_q + 16'h1;
        end
      end
      act_pkg::ACT_LATCHED: begin
        // recovery needs the user: clear the disable bit with the fault gone
        if (!overheat_retry_disable && !overheat_i) st_d = act_pkg::ACT_RUN;
      end
      default: st_d = act_pkg::ACT_RUN;
    endcase
    amp_en_d = (st_d == act_pkg::ACT_RUN) && otp_ready_d;
    latched_d = (st_d == act_pkg::ACT_LATCHED);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= act_pkg::ACT_RUN;
      retry_cnt_q <= '0;
      amp_en_q <= 1'b0;
      latched_q <= 1'b0;
    end else begin
      st_q <= st_d;
      retry_cnt_q <= retry_cnt_d;
      amp_en_q <= amp_en_d;
      latched_q <= latched_d;
    end
  end

  assign amp_enable_o = amp_en_q;
  assign overheat_latched_o = latched_q;

  // sense stream: sample load current and voltage at a fixed rate, always on
  logic [15:0] smp_cnt_q, smp_cnt_d;
  act_pkg::act_sense_t sense_q, sense_d;
  logic svalid_q, svalid_d;

  always_comb begin
    smp_cnt_d = smp_cnt_q + 16'h1;
    sense_d = sense_q;
    svalid_d = 1'b0;
    if (smp_cnt_q == 16'(SENSE_CYCLES - 1)) begin
      smp_cnt_d = '0;
      sense_d = sense_i; // [R6]
      svalid_d = 1'b1; // [R6]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      smp_cnt_q <= '0;
      sense_q <= '0;
      svalid_q <= 1'b0;
    end else begin
      smp_cnt_q <= smp_cnt_d;
      sense_q <= sense_d;
      svalid_q <= svalid_d;
    end
  end

  assign sense_o = sense_q;
  assign sense_valid_o = svalid_q;
endmodule : act_regs

// [verification/act_host.sv]
// host model: register port and transferred byte stream
// assumes the bench releases reset before any call
`timescale 1ns/1ps
module act_host (
  input wire logic sys_clk_i,
  input wire logic ready_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o = 0,
  output logic rd_o = 0,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00,
  output logic bv_o = 0,
  output logic [7:0] byte_o = 8'h00
);
  task automatic op(input logic w, r, input logic [7:0] a, d, input logic v,
    input logic [7:0] b);
    @(negedge sys_clk_i);
    {wr_o, rd_o, addr_o, wdata_o, bv_o, byte_o} = {w, r, a, d, v, b};
  endtask : op
  task automatic idle();
    @(negedge sys_clk_i);
    {wr_o, rd_o, bv_o} = 3'h0;
    // idle lines toggle so a stale value never looks valid
    {addr_o, wdata_o, byte_o} = ~{addr_o, wdata_o, byte_o};
  endtask : idle
  task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic ok);
    op(0, 1, a, 8'h00, 0, 8'h00);
    idle();
    {q, ok} = {rdata_i, rvalid_i};
  endtask : rd
  task automatic boot(output logic ok);
    for (int i = 0; i < 40 && ready_i !== 1'b1; i++) @(negedge sys_clk_i);
    ok = ready_i;
  endtask : boot
endmodule : act_host

// [verification/act_regs_chk.sv]
// port assertions for act_regs
// assumes the bench shortens the sense period
`timescale 1ns/1ps
module act_regs_chk #(parameter int SENSE_CYCLES = 8) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic bus_byte_valid_i,
  input wire logic [7:0] bus_byte_i,
  input wire logic overheat_i,
  input wire logic amp_enable_o,
  input wire logic overheat_latched_o,
  input wire logic sense_valid_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence wr_at(a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  sequence rd_at(a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no read valid");
  book_keep_a: assert property (wr_at(8'h7f) ##1 rd_at(8'h7f)
    |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("book readback wrong");
  crc_clear_a: assert property (wr_at(8'h7e) ##1 rd_at(8'h7e)
    |=> reg_rdata_o == 8'h00) else $error("checksum not cleared");
  crc_step_a: assert property (wr_at(8'h7e) ##1 bus_byte_valid_i && bus_byte_i == 8'h01
    ##1 rd_at(8'h7e) |=> reg_rdata_o == 8'h07) else $error("checksum step wrong");
  retry_off_a: assert property (overheat_latched_o |-> !amp_enable_o)
    else $error("amp on while latched");
  latch_hold_a: assert property (overheat_latched_o && overheat_i
    |=> overheat_latched_o && !amp_enable_o) else $error("latched fault released itself");
  fault_stop_a: assert property (amp_enable_o && overheat_i |=> !amp_enable_o)
    else $error("amp kept on in fault");
  sense_period_a: assert property (sense_valid_o |-> ##SENSE_CYCLES sense_valid_o)
    else $error("sense stream period wrong");
endmodule : act_regs_chk
bind act_regs act_regs_chk #(.SENSE_CYCLES(SENSE_CYCLES)) act_regs_chk_inst (.sys_clk_i,
  .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
  .bus_byte_valid_i, .bus_byte_i, .overheat_i, .amp_enable_o, .overheat_latched_o,
  .sense_valid_o);

// [verification/act_regs_tb_top.sv]
// bench for act_regs, one task per scenario
// assumes act_host drives the register port
`timescale 1ns/1ps
module act_regs_tb_top;
  logic sys_clk_i = 0;
  logic rst_i = 1;
  logic overheat_i = 0;
  logic reg_wr_i, reg_rd_i, bus_byte_valid_i, reg_rvalid_o, amp_enable_o;
  logic overheat_latched_o, otp_ready_o, sense_valid_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, bus_byte_i;
  act_pkg::act_sense_t sense_i = '0;
  act_pkg::act_sense_t sense_o;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  act_regs #(.RETRY_CYCLES(5), .SENSE_CYCLES(8), .OTP_CYCLES(10)) act_regs_inst (.sys_clk_i,
    .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
    .bus_byte_valid_i, .bus_byte_i, .overheat_i, .amp_enable_o, .overheat_latched_o,
    .otp_ready_o, .sense_i, .sense_o, .sense_valid_o);
  act_host act_host_inst (.sys_clk_i, .ready_i(otp_ready_o), .rvalid_i(reg_rvalid_o),
    .rdata_i(reg_rdata_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i), .bv_o(bus_byte_valid_i), .byte_o(bus_byte_i));
  task automatic final_report();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [39:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, exp);
    logic [7:0] q;
    logic ok;
    act_host_inst.rd(a, q, ok);
    chk("read valid", 1, ok);
    chk("read data", exp, q);
  endtask : rchk
  function automatic logic [7:0] crc8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) v = v[7] ? ((v << 1) ^ 8'h07) : (v << 1);
    return v;
  endfunction : crc8
  task automatic heat(input logic h);
    act_host_inst.idle();
    overheat_i = h;
    repeat (12) @(negedge sys_clk_i);
  endtask : heat
  task automatic t_book();
    act_host_inst.op(1, 0, 8'h7f, 8'hff, 0, 8'h00);
    rchk(8'h7f, 8'hff);
  endtask : t_book
  task automatic t_reset();
    logic ok;
    rst_i = 1;
    @(negedge sys_clk_i);
    chk("reset rdata", 8'h00, reg_rdata_o);
    chk("reset flags", 3'h0, {reg_rvalid_o, amp_enable_o, overheat_latched_o});
    chk("reset stream", 2'h0, {otp_ready_o, sense_valid_o});
    repeat (2) @(negedge sys_clk_i);
    rst_i = 0;
    repeat (2) @(negedge sys_clk_i);
    chk("otp wait", 2'h0, {amp_enable_o, otp_ready_o});
    act_host_inst.boot(ok);
    chk("otp ready again", 1, ok);
    rchk(8'h7f, 8'h00);
    rchk(8'h7e, 8'h00);
    rchk(8'h58, 8'h03);
  endtask : t_reset
  task automatic t_crc();
    act_host_inst.op(1, 0, 8'h7e, 8'h5a, 0, 8'h00);
    act_host_inst.op(0, 0, 8'h00, 8'h00, 1, 8'h01);
    rchk(8'h7e, 8'h07);
    act_host_inst.op(0, 0, 8'h00, 8'h00, 1, 8'hc3);
    rchk(8'h7e, crc8(8'h07 ^ 8'hc3));
    act_host_inst.op(1, 0, 8'h7e, 8'hc3, 1, 8'h99);
    rchk(8'h7e, 8'h00);
  endtask : t_crc
  task automatic t_prot();
    chk("amp on", 1, amp_enable_o);
    act_host_inst.op(1, 0, 8'h58, 8'h07, 0, 8'h00);
    rchk(8'h58, 8'h07);
    heat(1);
    chk("latched", 2'h1, {amp_enable_o, overheat_latched_o});
    act_host_inst.op(1, 0, 8'h58, 8'h03, 0, 8'h00);
    heat(0);
    chk("amp back", 1, amp_enable_o);
    heat(1);
    chk("retry wait", 2'h0, {amp_enable_o, overheat_latched_o});
    heat(0);
    chk("retried", 1, amp_enable_o);
  endtask : t_prot
  task automatic t_sense();
    sense_i = 32'h1234abcd;
    repeat (2) begin
      @(negedge sys_clk_i);
      for (int i = 0; i < 20 && sense_valid_o !== 1'b1; i++) @(negedge sys_clk_i);
    end
    chk("sense", {1'b1, 32'h1234abcd}, {sense_valid_o, sense_o});
  endtask : t_sense
  initial begin
    logic ok;
    repeat (10) @(negedge sys_clk_i);
    rst_i = 0;
    act_host_inst.boot(ok);
    chk("otp ready", 1, ok);
    rchk(8'h58, 8'h03);
    rchk(8'h7e, 8'h00);
    rchk(8'h7f, 8'h00);
    rchk(8'h10, 8'h00);
    t_book();
    t_reset();
    t_crc();
    t_prot();
    t_sense();
    final_report();
  end
endmodule : act_regs_tb_top
